// File: rtl/ccr_pkg.sv
// Purpose: Shared constants for the charger control register bank
// Assumes: 8-bit registers reached over an I2C slave port
// Notes: Timing counts derive from the 50 MHz system clock
package ccr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CHG_SET = 8'h04;
    localparam logic [7:0] ADDR_TTC = 8'h05;
    localparam logic [7:0] ADDR_PAC = 8'h06;
    localparam logic [7:0] ADDR_TRC = 8'h07;
    localparam logic [7:0] ADDR_STAT0 = 8'h0D;
    localparam logic [6:0] DEV_ADDR = 7'h11;
    // ------------------------------------------------------------
    // Reset values and write mask
    // ------------------------------------------------------------
    localparam logic RST_RECHARGE = 1'b1;
    localparam logic [7:0] RST_TTC = 8'hBB;
    localparam logic [7:0] RST_PAC = 8'h80;
    localparam logic [7:0] RST_TRC = 8'h39;
    localparam logic [7:0] PAC_WMASK = 8'hBB;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_WD_ON = 7;
    localparam int B_WD_HI = 6;
    localparam int B_WD_LO = 5;
    localparam int B_TERM_ON = 4;
    localparam int B_TMR_ON = 3;
    localparam int B_FC_HI = 2;
    localparam int B_FC_LO = 1;
    localparam int B_AUX_ON = 0;
    localparam int B_THERM_ON = 7;
    localparam int B_BSW_OFF = 5;
    localparam int B_PG_AL = 4;
    localparam int B_EOC_AL = 3;
    localparam int B_NTC_AL = 1;
    localparam int B_OVP_AL = 0;
    localparam int B_WD_FAULT = 7;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int ALERT_US = 125;
    localparam int ALERT_CYC = (ALERT_US * (CLK_HZ / 1_000_000));
    localparam int TICK_HZ = 10;
    localparam int TICK_CYC = CLK_HZ / TICK_HZ;
    localparam int WD_BASE_S = 10;
    localparam int FC_H3 = 3;
    localparam int FC_H5 = 5;
    localparam int FC_H8 = 8;
    localparam int FC_H12 = 12;
    localparam int SEC_PER_H = 3600;
endpackage

// File: rtl/ccr_reg_if.sv
// Purpose: Register access strobes between serial front end and bank
// Assumes: Strobes and rdata on mclk; addr and wdata are held stable from the scl side
// Notes: Pulses are one mclk cycle wide
`timescale 1ns/10ps
interface ccr_reg_if;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport front (output wr_stb, rd_stb, addr, wdata, input rdata);
    modport bank (input wr_stb, rd_stb, addr, wdata, output rdata);
endinterface

// File: rtl/ccr_i2c_slave.sv
// Purpose: I2C slave front end on its own SCL clock domain
// Assumes: Host writes offset then data; reads continue from offset
// Notes: Events cross to mclk by toggle, words held stable meanwhile
`timescale 1ns/10ps
module ccr_i2c_slave
    import ccr_pkg::*;
(
    // Clocks and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl,
    // Serial data pin
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Register side
    ccr_reg_if.front rb
);
    typedef enum logic [2:0] {
        CCR_IDLE, CCR_DEVA, CCR_ACK, CCR_RX, CCR_TX, CCR_TACK
    } ccr_st_t;
    // ------------------------------------------------------------
    // Start and stop detection, async to scl edges
    // ------------------------------------------------------------
    logic start_t, stop_t;
    always_ff @(negedge sda_in or negedge rst_n) begin
        if (!rst_n) begin
            start_t <= 1'b0;
        end else if (scl) begin
            start_t <= ~start_t;
        end
    end
    always_ff @(posedge sda_in or negedge rst_n) begin
        if (!rst_n) begin
            stop_t <= 1'b0;
        end else if (scl) begin
            stop_t <= ~stop_t;
        end
    end
    // ------------------------------------------------------------
    // Bit engine on scl
    // ------------------------------------------------------------
    ccr_st_t st, next_st;
    logic [7:0] sh, next_sh;
    logic [2:0] cnt, next_cnt;
    logic rnw, next_rnw;
    logic have_off, next_have_off;
    logic [7:0] off, next_off;
    logic start_d, stop_d;
    logic wr_tg, next_wr_tg, rd_tg, next_rd_tg;
    logic [7:0] wd, next_wd;
    always_comb begin
        next_st = st;
        next_sh = {sh[6:0], sda_in};
        next_cnt = cnt + 3'd1;
        next_rnw = rnw;
        next_have_off = have_off;
        next_off = off;
        next_wr_tg = wr_tg;
        next_rd_tg = rd_tg;
        next_wd = wd;
        if (start_t != start_d) begin
            next_st = CCR_DEVA;
            next_cnt = 3'd1;
            next_sh = {7'h00, sda_in};
            next_have_off = 1'b0;
        end else if (stop_t != stop_d) begin
            next_st = CCR_IDLE;
        end else begin
            case (st)
                CCR_DEVA: begin
                    if (cnt == 3'd7) begin
                        next_rnw = sda_in;
                        next_st = (sh[6:0] == DEV_ADDR) ? CCR_ACK : CCR_IDLE;
                    end
                end
                CCR_ACK: begin
                    next_cnt = 3'd0;
                    next_st = rnw ? CCR_TX : CCR_RX;
                end
                CCR_RX: begin
                    if (cnt == 3'd7) begin
                        next_st = CCR_ACK;
                        if (!have_off) begin
                            next_off = {sh[6:0], sda_in};
                            next_have_off = 1'b1;
                        end else begin
                            next_wd = {sh[6:0], sda_in};
                            next_wr_tg = ~wr_tg;
                            next_off = off + 8'h01;
                        end
                    end
                end
                CCR_TX: begin
                    if (cnt == 3'd7) begin
                        next_st = CCR_TACK;
                        // Strobe after the byte is loaded, so a clear on
                        // read cannot wipe the value being sent
                        next_rd_tg = ~rd_tg;
                    end
                end
                CCR_TACK: begin
                    next_cnt = 3'd0;
                    next_off = off + 8'h01;
                    next_st = sda_in ? CCR_IDLE : CCR_TX;
                end
                default: begin
                    next_st = CCR_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            st <= CCR_IDLE;
            sh <= 8'h00;
            cnt <= 3'd0;
            rnw <= 1'b0;
            have_off <= 1'b0;
            off <= 8'h00;
            start_d <= 1'b0;
            stop_d <= 1'b0;
            wr_tg <= 1'b0;
            rd_tg <= 1'b0;
            wd <= 8'h00;
        end else begin
            st <= next_st;
            sh <= next_sh;
            cnt <= next_cnt;
            rnw <= next_rnw;
            have_off <= next_have_off;
            off <= next_off;
            start_d <= start_t;
            stop_d <= stop_t;
            wr_tg <= next_wr_tg;
            rd_tg <= next_rd_tg;
            wd <= next_wd;
        end
    end
    // ------------------------------------------------------------
    // Drive sda on falling scl; read data sampled from mclk side
    // ------------------------------------------------------------
    logic [7:0] txsh;
    logic drv_lo;
    always_ff @(negedge scl or negedge rst_n) begin
        if (!rst_n) begin
            drv_lo <= 1'b0;
            txsh <= 8'h00;
        end else if (st == CCR_ACK) begin
            // Acknowledge address and written bytes alike
            drv_lo <= 1'b1;
        end else if (st == CCR_TX && cnt == 3'd0) begin
            drv_lo <= ~rb.rdata[7];
            txsh <= {rb.rdata[6:0], 1'b0};
        end else if (st == CCR_TX) begin
            drv_lo <= ~txsh[7];
            txsh <= {txsh[6:0], 1'b0};
        end else begin
            drv_lo <= 1'b0;
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe_n = ~drv_lo;
    // ------------------------------------------------------------
    // Toggle crossings into mclk; words are stable for many mclks
    // ------------------------------------------------------------
    logic [2:0] wsy, rsy;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wsy <= 3'b000;
            rsy <= 3'b000;
        end else begin
            wsy <= {wsy[1:0], wr_tg};
            rsy <= {rsy[1:0], rd_tg};
        end
    end
    assign rb.wr_stb = wsy[2] ^ wsy[1];
    assign rb.rd_stb = rsy[2] ^ rsy[1];
    assign rb.addr = rb.wr_stb ? (off - 8'h01) : off;
    assign rb.wdata = wd;
endmodule

// File: rtl/ccr_top.sv
// Purpose: Charger control register bank with timers and alert pin
// Assumes: Register access only over the I2C slave port
// Notes: Time base ticks at 10 Hz from mclk
`timescale 1ns/10ps
module ccr_top
    import ccr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Serial link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Charger events and modes
    input wire logic ev_input_good,
    input wire logic ev_end_charge,
    input wire logic ev_thermistor,
    input wire logic ev_overvoltage,
    input wire logic shipping_mode,
    input wire logic low_power_mode,
    input wire logic fast_charge_active,
    // Controls to charger
    output logic recharge_threshold_select,
    output logic termination_on,
    output logic thermistor_monitor_on,
    output logic battery_switch_off,
    output logic aux_regulator_out,
    output logic safety_expired,
    output logic watchdog_expired,
    output logic alert_n
);

    // ------------------------------------------------------------
    // Serial front end
    // ------------------------------------------------------------
    ccr_reg_if rb ();
    ccr_i2c_slave u_slave (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl(scl),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .rb(rb)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic rchg, next_rchg;
    logic [7:0] ttc, next_ttc, pac, next_pac, trc, next_trc;
    logic wd_flag, next_wd_flag;
    logic wd_hit, fc_hit;
    always_comb begin
        next_rchg = rchg;
        next_ttc = ttc;
        next_pac = pac;
        next_trc = trc;
        next_wd_flag = wd_flag;
        if (rb.wr_stb) begin
            if (rb.addr == ADDR_CHG_SET) begin
                next_rchg = rb.wdata[0];
            end else if (rb.addr == ADDR_TTC) begin
                next_ttc = rb.wdata;
            end else if (rb.addr == ADDR_PAC) begin
                next_pac = rb.wdata & PAC_WMASK;
            end else if (rb.addr == ADDR_TRC) begin
                next_trc = rb.wdata;
            end
        end
        // Set wins over the read clear
        if (rb.rd_stb && rb.addr == ADDR_STAT0) begin
            next_wd_flag = 1'b0;
        end
        if (wd_hit) begin
            next_wd_flag = 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rchg <= RST_RECHARGE;
            ttc <= RST_TTC;
            pac <= RST_PAC;
            trc <= RST_TRC;
            wd_flag <= 1'b0;
        end else begin
            rchg <= next_rchg;
            ttc <= next_ttc;
            pac <= next_pac;
            trc <= next_trc;
            wd_flag <= next_wd_flag;
        end
    end
    always_comb begin
        rb.rdata = 8'h00;
        if (rb.addr == ADDR_CHG_SET) begin
            rb.rdata = {7'h00, rchg};
        end else if (rb.addr == ADDR_TTC) begin
            rb.rdata = ttc;
        end else if (rb.addr == ADDR_PAC) begin
            rb.rdata = pac;
        end else if (rb.addr == ADDR_TRC) begin
            rb.rdata = trc;
        end else if (rb.addr == ADDR_STAT0) begin
            rb.rdata = {wd_flag, 7'h00};
        end
    end

    // ------------------------------------------------------------
    // Time base and timers
    // ------------------------------------------------------------
    function automatic logic [31:0] wd_limit(input logic [1:0] sel);
        wd_limit = 32'((WD_BASE_S * TICK_HZ) << sel);
    endfunction
    function automatic logic [31:0] fc_limit(input logic [1:0] sel);
        logic [31:0] h;
        h = 32'(FC_H12);
        case (sel)
            2'b00: h = 32'(FC_H3);
            2'b01: h = 32'(FC_H5);
            2'b10: h = 32'(FC_H8);
            default: h = 32'(FC_H12);
        endcase
        fc_limit = 32'(h * SEC_PER_H * TICK_HZ);
    endfunction
    logic [31:0] pre, next_pre, wd_cnt, next_wd_cnt, fc_cnt, next_fc_cnt;
    logic tick, tmr_d, fc_done, next_fc_done;
    logic [31:0] al_cnt, next_al_cnt;
    logic [3:0] ev_d;
    logic [3:0] ev_rise;
    assign tick = (pre == 32'(TICK_CYC - 1));
    always_comb begin
        next_pre = tick ? 32'h0000_0000 : pre + 32'h0000_0001;
        next_wd_cnt = wd_cnt;
        next_fc_cnt = fc_cnt;
        next_fc_done = fc_done;
        wd_hit = 1'b0;
        fc_hit = 1'b0;
        if (!ttc[B_WD_ON] || rb.wr_stb || rb.rd_stb) begin
            next_wd_cnt = 32'h0000_0000;
        end else if (tick) begin
            if (wd_cnt + 32'h0000_0001 >= wd_limit(ttc[B_WD_HI:B_WD_LO])) begin
                wd_hit = 1'b1;
                next_wd_cnt = 32'h0000_0000;
            end else begin
                next_wd_cnt = wd_cnt + 32'h0000_0001;
            end
        end
        if (ttc[B_TMR_ON] && !tmr_d) begin
            next_fc_cnt = 32'h0000_0000;
            next_fc_done = 1'b0;
        end else if (ttc[B_TMR_ON] && fast_charge_active && tick
                     && !fc_done) begin
            if (fc_cnt + 32'h0000_0001 >= fc_limit(ttc[B_FC_HI:B_FC_LO])) begin
                fc_hit = 1'b1;
                next_fc_done = 1'b1;
            end
            next_fc_cnt = fc_cnt + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Alert pulse
    // ------------------------------------------------------------
    logic [3:0] ev_allow;
    assign ev_allow = {pac[B_PG_AL], pac[B_EOC_AL], pac[B_NTC_AL],
                       pac[B_OVP_AL]};
    assign ev_rise = {ev_input_good, ev_end_charge, ev_thermistor,
                      ev_overvoltage} & ~ev_d & ev_allow;
    always_comb begin
        next_al_cnt = al_cnt;
        if (al_cnt != 32'h0000_0000) begin
            next_al_cnt = al_cnt - 32'h0000_0001;
        end else if (ev_rise != 4'h0) begin
            next_al_cnt = 32'(ALERT_CYC);
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre <= 32'h0000_0000;
            wd_cnt <= 32'h0000_0000;
            fc_cnt <= 32'h0000_0000;
            fc_done <= 1'b0;
            tmr_d <= 1'b1;
            al_cnt <= 32'h0000_0000;
            ev_d <= 4'h0;
        end else begin
            pre <= next_pre;
            wd_cnt <= next_wd_cnt;
            fc_cnt <= next_fc_cnt;
            fc_done <= next_fc_done;
            tmr_d <= ttc[B_TMR_ON];
            al_cnt <= next_al_cnt;
            ev_d <= {ev_input_good, ev_end_charge, ev_thermistor,
                     ev_overvoltage};
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign recharge_threshold_select = rchg;
    assign termination_on = ttc[B_TERM_ON];
    assign thermistor_monitor_on = pac[B_THERM_ON];
    assign battery_switch_off = pac[B_BSW_OFF];
    assign aux_regulator_out = ttc[B_AUX_ON] & ~shipping_mode
                               & ~low_power_mode;
    assign safety_expired = fc_done;
    assign watchdog_expired = wd_flag;
    assign alert_n = (al_cnt == 32'h0000_0000);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_aux_gating: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (shipping_mode || low_power_mode) |-> !aux_regulator_out)
        else $error("aux output active in off mode");

    a_alert_len: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $rose(al_cnt == 32'(ALERT_CYC)) |-> !alert_n)
        else $error("alert pulse not low");

    a_alert_hold: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (!alert_n && al_cnt != 32'h0000_0001) |=> !alert_n)
        else $error("alert pulse ended early");

    a_alert_end: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (al_cnt == 32'h0000_0001) |=> alert_n)
        else $error("alert pulse too long");

    a_wd_set: assert property (@(posedge mclk)
        disable iff (!rst_n)
        wd_hit |=> wd_flag)
        else $error("watchdog flag not set");

    a_wd_clear: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (rb.rd_stb && rb.addr == ADDR_STAT0 && !wd_hit) |=> !wd_flag)
        else $error("watchdog flag not cleared");

    a_wd_kick: assert property (@(posedge mclk)
        disable iff (!rst_n)
        rb.wr_stb |=> wd_cnt == 32'h0000_0000)
        else $error("watchdog not restarted");

    a_rd_kick: assert property (@(posedge mclk)
        disable iff (!rst_n)
        rb.rd_stb |=> wd_cnt == 32'h0000_0000)
        else $error("watchdog not restarted by read");

    a_wd_off: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !ttc[B_WD_ON] |=> wd_cnt == 32'h0000_0000)
        else $error("watchdog counts while off");

    a_tmr_restart: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $rose(ttc[B_TMR_ON]) |=> fc_cnt == 32'h0000_0000)
        else $error("safety timer not restarted");

    a_tmr_hold: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (!ttc[B_TMR_ON] || (tmr_d && !fast_charge_active))
        |=> $stable(fc_cnt))
        else $error("safety timer counts while held");

    a_fc_done: assert property (@(posedge mclk)
        disable iff (!rst_n)
        fc_hit |=> safety_expired)
        else $error("safety expiry not flagged");

    a_pac_rsv: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (pac & ~PAC_WMASK) == 8'h00)
        else $error("reserved bits set");

    a_bsw_map: assert property (@(posedge mclk)
        disable iff (!rst_n)
        battery_switch_off == pac[B_BSW_OFF])
        else $error("switch output mismatch");
endmodule

// File: tb/ccr_host_model.sv
// Purpose: Host model for the I2C side of the charger register bank
// Assumes: Open-drain SDA with pull-up; SCL idle high between frames
// Notes: SCL phases last 6 link clocks so the bank's crossings keep up
`timescale 1ns/10ps
module ccr_host_model
    import ccr_pkg::*;
(
    // Serial link
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    // ----------
    // Link clock
    // ----------
    logic lclk;
    initial begin
        lclk = 1'b0;
        #7;
        forever #15 lclk = ~lclk;
    end
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // ----------
    // Bus cycles
    // ----------
    task automatic ph();
        repeat (6) @(posedge lclk);
    endtask
    task automatic high();
        ph();
        scl = 1'b1;
        ph();
    endtask
    // SDA only moves one link clock after SCL falls, so the bank
    // never sees a data change as a start or stop
    task automatic fall();
        scl = 1'b0;
        @(posedge lclk);
    endtask
    task automatic start();
        sda_pull = 1'b0;
        high();
        sda_pull = 1'b1;
        ph();
        fall();
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        high();
        sda_pull = 1'b0;
        ph();
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~d[i];
            high();
            fall();
        end
        sda_pull = 1'b0;
        high();
        ack = ~sda_line;
        fall();
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        sda_pull = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            high();
            d[i] = sda_line;
            fall();
        end
        // Last byte is refused so the bank lets go of SDA before stop
        sda_pull = ~last;
        high();
        fall();
    endtask
    // Every access also restarts the bank's watchdog
    task automatic write_reg(input logic [7:0] off, input logic [7:0] v,
                             output logic ok);
        logic a0, a1, a2;
        start();
        send({DEV_ADDR, 1'b0}, a0);
        send(off, a1);
        send(v, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic read_reg(input logic [7:0] off, output logic [7:0] d,
                            output logic ok);
        logic a0, a1, a2;
        start();
        send({DEV_ADDR, 1'b0}, a0);
        send(off, a1);
        start();
        send({DEV_ADDR, 1'b1}, a2);
        recv(1'b1, d);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

// File: tb/tb_charger_control_registers.sv
// Purpose: Self-checking bench for the charger register bank
// Assumes: Host model owns SCL and its share of SDA
// Notes: Watchdog and safety timer spans are far beyond a run
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("mismatch at %0t got %0h expected %0h", \
                     $time, (got), (exp)); \
        end \
    end
module tb_charger_control_registers
    import ccr_pkg::*;
;
    // ----------
    // Signals
    // ----------
    logic mclk, rst_n, ship, lowp, fca;
    logic [3:0] ev;
    logic scl, sda_pull, sda_out, sda_oe_n, sda_line;
    logic rts, term, therm, bsw, aux, saf, wd, alert_n;
    int failures, comparisons, cycles, low_cnt;
    logic [7:0] pat [3] = '{8'h00, 8'hFF, 8'h5A};
    logic [7:0] ebit [4] = '{8'h10, 8'h08, 8'h02, 8'h01};
    assign sda_line = ~sda_pull & (sda_oe_n | sda_out);
    ccr_top u_dut (.mclk(mclk), .rst_n(rst_n), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .ev_input_good(ev[0]), .ev_end_charge(ev[1]),
        .ev_thermistor(ev[2]), .ev_overvoltage(ev[3]),
        .shipping_mode(ship), .low_power_mode(lowp),
        .fast_charge_active(fca), .recharge_threshold_select(rts),
        .termination_on(term), .thermistor_monitor_on(therm),
        .battery_switch_off(bsw), .aux_regulator_out(aux),
        .safety_expired(saf), .watchdog_expired(wd), .alert_n(alert_n));
    ccr_host_model u_host (.scl(scl), .sda_pull(sda_pull),
        .sda_line(sda_line));
    // ----------
    // Tasks
    // ----------
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] v);
        logic ok;
        u_host.write_reg(off, v, ok);
        `CHK(ok, 1'b1);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] off, mask, exp);
        logic ok;
        logic [7:0] d;
        u_host.read_reg(off, d, ok);
        `CHK(ok, 1'b1);
        `CHK(d & mask, exp);
    endtask
    task automatic modes(input logic s, input logic l, input logic exp);
        @(posedge mclk);
        ship <= s;
        lowp <= l;
        @(negedge mclk);
        `CHK(aux, exp);
    endtask
    // A masked event still waits a little, in case the pulse is late
    task automatic alert(input int j, input int exp_cnt);
        @(posedge mclk);
        low_cnt = 0;
        ev[j] <= 1'b1;
        repeat (4) @(posedge mclk);
        ev[j] <= 1'b0;
        repeat (exp_cnt + 200) @(posedge mclk);
        `CHK(low_cnt, exp_cnt);
        `CHK(alert_n, 1'b1);
    endtask
    // ----------
    // Stimulus
    // ----------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(negedge mclk) if (alert_n === 1'b0) low_cnt++;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        rst_n = 1'b0;
        ev = 4'h0;
        ship = 1'b0;
        lowp = 1'b0;
        fca = 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        `CHK(rts, 1'b1);
        `CHK(term, 1'b1);
        `CHK(therm, 1'b1);
        `CHK(bsw, 1'b0);
        `CHK(aux, 1'b1);
        `CHK(alert_n, 1'b1);
        `CHK(wd, 1'b0);
        `CHK(saf, 1'b0);
        rd(8'h04, 8'h01, 8'h01);
        rd(8'h05, 8'hFF, 8'hBB);
        rd(8'h06, 8'hFF, 8'h80);
        rd(8'h07, 8'h80, 8'h00);
        rd(8'h0D, 8'h80, 8'h00);
        $display("test reset_values done");
        foreach (pat[k]) begin
            wr(8'h05, pat[k]);
            rd(8'h05, 8'hFF, pat[k]);
            `CHK(term, pat[k][4]);
            `CHK(aux, pat[k][0]);
            wr(8'h06, pat[k]);
            rd(8'h06, 8'hFF, pat[k] & 8'hBB);
            `CHK(therm, pat[k][7]);
            `CHK(bsw, pat[k][5]);
        end
        wr(8'h04, 8'h00);
        `CHK(rts, 1'b0);
        rd(8'h04, 8'h01, 8'h00);
        wr(8'h0A, 8'h55);
        rd(8'h0A, 8'hFF, 8'h00);
        $display("test field_walk done");
        wr(8'h05, 8'hBB);
        modes(1'b1, 1'b0, 1'b0);
        modes(1'b0, 1'b1, 1'b0);
        modes(1'b0, 1'b0, 1'b1);
        $display("test aux_modes done");
        wr(8'h06, 8'h80);
        for (int j = 0; j < 4; j++) alert(j, 0);
        for (int j = 0; j < 4; j++) begin
            wr(8'h06, 8'h80 | ebit[j]);
            alert(j, ALERT_CYC);
        end
        $display("test alerts done");
        wrap_up();
    end
endmodule
